// ===== shared/obps_regs.svh
// register offsets, field positions, keys, protect codes and timing counts of the option sequencer
`ifndef OBPS_REGS_SVH
`define OBPS_REGS_SVH
// register byte offsets (word aligned)
`define OBPS_OFF_KEY 8'h00
`define OBPS_OFF_CTRL 8'h04
`define OBPS_OFF_STAT 8'h08
`define OBPS_OFF_ADDR 8'h0C
`define OBPS_OFF_DATA 8'h10
`define OBPS_OFF_OPT 8'h14
`define OBPS_OFF_WPS 8'h18
`define OBPS_OFF_RDBK 8'h1C
// control bits
`define OBPS_CTL_OPTION_ERASE 0
`define OBPS_CTL_START_TRIGGER 1
`define OBPS_CTL_FAST_PAGE_PROGRAM 2
`define OBPS_CTL_BCLR 3
`define OBPS_CTL_BLOAD 4
`define OBPS_CTL_OWE 5
// status bits
`define OBPS_ST_BSY 0
`define OBPS_ST_WBSY 1
`define OBPS_ST_DONE 2
`define OBPS_ST_ERR 3
// unlock keys and protect codes
`define OBPS_KEY_FIRST 32'h45670123
`define OBPS_KEY_SECOND 32'hCDEF89AB
`define OBPS_UNPROT 8'hA5
`define OBPS_UNPROT_N 8'h5A
// option image erased value and factory image
`define OBPS_ERASED 32'hFFFFFFFF
`define OBPS_OPT_DEFAULT 32'h5AA5_5AA5
// operation times in ns and cycles at 50 MHz
`define OBPS_CLK_NS 20
`define OBPS_T_BCLR_NS 40
`define OBPS_T_LOAD_NS 40
`define OBPS_T_PROG_NS 2000
`define OBPS_T_ERASE_NS 4000
`define OBPS_T_MERASE_NS 8000
`define OBPS_CYC(ns) (((ns) + `OBPS_CLK_NS - 1) / `OBPS_CLK_NS)
`endif

// ===== shared/obps_pkg.sv
// types shared by the option byte sequencer
package obps_pkg;
    typedef enum logic [2:0] {
        OBPS_IDLE = 3'b000,
        OBPS_BCLR = 3'b001,
        OBPS_LOAD = 3'b010,
        OBPS_PROG = 3'b011,
        OBPS_ERASE = 3'b100,
        OBPS_MERASE = 3'b101
    } obps_state_t;
    typedef enum logic [1:0] {
        OBPS_K_NONE = 2'b00,
        OBPS_K_HALF = 2'b01
    } obps_key_t;
endpackage

// ===== hw/obps_timer.sv
// down counter that times one flash operation and pulses when it expires
`timescale 1ns/100ps
`default_nettype none
module obps_timer #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic expired,
    output logic running
);
    logic [WIDTH-1:0] remain;

    // count down after a load, pulse at the last cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    assign running = (remain != '0);
    assign expired = (remain == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// ===== hw/obps_seq.sv
// option byte program and erase sequencer with avalon-mm register slave
// Operation
// - option unlock needs first key then second key written to key register
// - correct key pair sets option write enable
// - clearing option write enable relocks; erase and program then refused
// - fast page program bit selects fast page programming
// - buffer clear empties the page buffer, done flag marks completion
// - each 32-bit word is latched by buffer load; write busy shows progress
// - address then start bit programs the buffered page
// - page end shown by busy low and done flag; software checks errors
// - lifting read protection erases whole main memory automatically
// - option erase bit then start erases whole option area, needs enable
// - erased option bytes read back as all ones
// - option status bit reads one while flash is read protected
// - option erase alone does not lift read protection
// - new read protect code acts only after reset reload
// - write protect status bit per 2K region, one means writable
// - new write protect bytes act only after reset reload
// - unprotected only when code is A5 and complement is 5A
// - each option byte is stored beside its inverse in a word
`timescale 1ns/100ps
`default_nettype none
`include "obps_regs.svh"
module obps_seq #(
    parameter int WORDS = 16,
    parameter int OPT_WORDS = 4,
    parameter int TW = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // flash array side
    output logic main_erase_req,
    output logic [31:0] prog_word,
    output logic prog_word_valid,
    output logic [$clog2(WORDS)-1:0] prog_word_idx
);
    import obps_pkg::*;

    localparam logic [TW-1:0] CYC_BCLR = TW'(`OBPS_CYC(`OBPS_T_BCLR_NS));
    localparam logic [TW-1:0] CYC_LOAD = TW'(`OBPS_CYC(`OBPS_T_LOAD_NS));
    localparam logic [TW-1:0] CYC_PROG = TW'(`OBPS_CYC(`OBPS_T_PROG_NS));
    localparam logic [TW-1:0] CYC_ERASE = TW'(`OBPS_CYC(`OBPS_T_ERASE_NS));
    localparam logic [TW-1:0] CYC_MERASE = TW'(`OBPS_CYC(`OBPS_T_MERASE_NS));
    localparam int IW = $clog2(WORDS);

    obps_state_t state;
    obps_key_t key_state;
    logic option_write_enable;
    logic option_erase;
    logic fast_page_program;
    logic operation_done_flag;
    logic err_flag;
    logic [31:0] page_addr;
    logic [31:0] data_stage;
    logic [31:0] page_buf [WORDS];
    logic [IW-1:0] load_ptr;
    logic [IW:0] prog_ptr;
    logic [31:0] opt_img [OPT_WORDS] = '{default: `OBPS_OPT_DEFAULT}; // factory image before any erase
    logic read_protect_active;
    logic [31:0] write_protect_status;
    logic reload_pending;
    logic lift_pending;
    logic t_load;
    logic [TW-1:0] t_count;
    logic t_expired;
    logic rd_ack;
    logic busy;
    logic write_busy;
    logic ctl_wr;
    logic start_req;
    logic bclr_req;
    logic bload_req;
    logic [1:0] opt_sel;

    ////////////////////////////////////////////////////////////////
    // bus handshake: writes take one cycle, reads take two
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ack <= 1'b0;
        end else begin
            rd_ack <= read && !rd_ack;
        end
    end
    assign waitrequest = read && !rd_ack;

    assign busy = (state != OBPS_IDLE);
    assign write_busy = (state == OBPS_LOAD);
    assign ctl_wr = write && (address == `OBPS_OFF_CTRL);
    // requests while busy are dropped; the running operation stays intact
    assign start_req = ctl_wr && writedata[`OBPS_CTL_START_TRIGGER] && !busy;
    assign bclr_req = ctl_wr && writedata[`OBPS_CTL_BCLR] && !busy;
    assign bload_req = ctl_wr && writedata[`OBPS_CTL_BLOAD] && !busy;
    assign opt_sel = page_addr[3:2];

    ////////////////////////////////////////////////////////////////
    // two-key unlock; any stray value drops back to locked
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            key_state <= OBPS_K_NONE;
            option_write_enable <= 1'b0;
        end else if (write && address == `OBPS_OFF_KEY) begin
            if (key_state == OBPS_K_NONE && writedata == `OBPS_KEY_FIRST) begin
                key_state <= OBPS_K_HALF;
            end else if (key_state == OBPS_K_HALF && writedata == `OBPS_KEY_SECOND) begin
                key_state <= OBPS_K_NONE;
                option_write_enable <= 1'b1;
            end else begin
                key_state <= OBPS_K_NONE;
                option_write_enable <= 1'b0;
            end
        end else if (ctl_wr && !writedata[`OBPS_CTL_OWE]) begin
            option_write_enable <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // mode bits held in the control register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            option_erase <= 1'b0;
            fast_page_program <= 1'b0;
        end else if (ctl_wr) begin
            option_erase <= writedata[`OBPS_CTL_OPTION_ERASE];
            fast_page_program <= writedata[`OBPS_CTL_FAST_PAGE_PROGRAM];
        end
    end

    // address and staged data words
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_addr <= 32'h0000_0000;
            data_stage <= 32'h0000_0000;
        end else if (write && address == `OBPS_OFF_ADDR) begin
            page_addr <= writedata;
        end else if (write && address == `OBPS_OFF_DATA) begin
            data_stage <= writedata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // operation sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= OBPS_IDLE;
        end else begin
            case (state)
                OBPS_IDLE: begin
                    if (bclr_req && fast_page_program) begin
                        state <= OBPS_BCLR;
                    end else if (bload_req && fast_page_program) begin
                        state <= OBPS_LOAD;
                    end else if (start_req && option_write_enable && option_erase) begin
                        state <= OBPS_ERASE;
                    end else if (start_req && option_write_enable && fast_page_program) begin
                        state <= OBPS_PROG;
                    end
                end
                OBPS_PROG: begin
                    if (t_expired) begin
                        state <= lift_pending ? OBPS_MERASE : OBPS_IDLE;
                    end
                end
                OBPS_BCLR, OBPS_LOAD, OBPS_ERASE, OBPS_MERASE: begin
                    if (t_expired) begin
                        state <= OBPS_IDLE;
                    end
                end
                default: begin
                    state <= OBPS_IDLE;
                end
            endcase
        end
    end

    // timer load on entry to every state except idle
    always_comb begin
        t_load = 1'b0;
        t_count = CYC_BCLR;
        if (state == OBPS_IDLE && bclr_req && fast_page_program) begin
            t_load = 1'b1;
            t_count = CYC_BCLR;
        end else if (state == OBPS_IDLE && bload_req && fast_page_program) begin
            t_load = 1'b1;
            t_count = CYC_LOAD;
        end else if (state == OBPS_IDLE && start_req && option_write_enable && option_erase) begin
            t_load = 1'b1;
            t_count = CYC_ERASE;
        end else if (state == OBPS_IDLE && start_req && option_write_enable && fast_page_program) begin
            t_load = 1'b1;
            t_count = CYC_PROG;
        end else if (state == OBPS_PROG && t_expired && lift_pending) begin
            t_load = 1'b1;
            t_count = CYC_MERASE;
        end
    end

    obps_timer #(
        .WIDTH(TW)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .load(t_load),
        .count(t_count),
        .expired(t_expired),
        .running()
    );

    ////////////////////////////////////////////////////////////////
    // page buffer; clear fills it with ones, loads advance the pointer
    always_ff @(posedge clk) begin
        if (state == OBPS_BCLR && t_expired) begin
            for (int i = 0; i < WORDS; i++) begin
                page_buf[i] <= `OBPS_ERASED;
            end
        end else if (state == OBPS_LOAD && t_expired) begin
            page_buf[load_ptr] <= data_stage;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_ptr <= '0;
        end else if (state == OBPS_BCLR && t_expired) begin
            load_ptr <= '0;
        end else if (state == OBPS_LOAD && t_expired) begin
            load_ptr <= load_ptr + 1'b1;
        end
    end

    // stream the page to the array while programming
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prog_ptr <= '0;
            prog_word <= 32'h0000_0000;
            prog_word_valid <= 1'b0;
            prog_word_idx <= '0;
        end else if (state == OBPS_PROG && prog_ptr < (IW+1)'(WORDS)) begin
            prog_ptr <= prog_ptr + 1'b1;
            prog_word <= page_buf[prog_ptr[IW-1:0]];
            prog_word_valid <= 1'b1;
            prog_word_idx <= prog_ptr[IW-1:0];
        end else begin
            if (state != OBPS_PROG) begin
                prog_ptr <= '0;
            end
            prog_word_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // option image: erase to ones, program copies the first OPT_WORDS buffer words
    // non-volatile, so reset leaves it alone and only reloads protection from it
    always_ff @(posedge clk) begin
        if (state == OBPS_ERASE && t_expired) begin
            for (int i = 0; i < OPT_WORDS; i++) begin
                opt_img[i] <= `OBPS_ERASED;
            end
        end else if (state == OBPS_PROG && t_expired) begin
            for (int i = 0; i < OPT_WORDS; i++) begin
                opt_img[i] <= page_buf[i];
            end
        end
    end

    // a protected part becomes unprotected only via a full main erase
    always_comb begin
        lift_pending = read_protect_active && page_buf[0][7:0] == `OBPS_UNPROT
            && page_buf[0][15:8] == `OBPS_UNPROT_N;
    end

    ////////////////////////////////////////////////////////////////
    // protection state is latched once after reset release, not live
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reload_pending <= 1'b1;
            read_protect_active <= 1'b1;
            write_protect_status <= 32'h0000_0000;
        end else if (reload_pending) begin
            reload_pending <= 1'b0;
            read_protect_active <= !(opt_img[0][7:0] == `OBPS_UNPROT
                && opt_img[0][15:8] == `OBPS_UNPROT_N);
            write_protect_status <= {opt_img[3][23:16], opt_img[3][7:0],
                opt_img[2][23:16], opt_img[2][7:0]};
        end
    end

    ////////////////////////////////////////////////////////////////
    // done and error flags; the set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            operation_done_flag <= 1'b0;
            err_flag <= 1'b0;
        end else begin
            if (state != OBPS_IDLE && state != OBPS_LOAD && t_expired
                && !(state == OBPS_PROG && lift_pending)) begin
                operation_done_flag <= 1'b1;
            end else if (write && address == `OBPS_OFF_STAT && writedata[`OBPS_ST_DONE]) begin
                operation_done_flag <= 1'b0;
            end
            if (start_req && !option_write_enable) begin
                err_flag <= 1'b1;
            end else if (write && address == `OBPS_OFF_STAT && writedata[`OBPS_ST_ERR]) begin
                err_flag <= 1'b0;
            end
        end
    end

    assign main_erase_req = (state == OBPS_MERASE);

    ////////////////////////////////////////////////////////////////
    // read data mux, unmapped reads return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read && !rd_ack) begin
            case (address)
                `OBPS_OFF_CTRL: readdata <= {26'h0, option_write_enable, 2'b00,
                    fast_page_program, 1'b0, option_erase};
                `OBPS_OFF_STAT: readdata <= {28'h0, err_flag, operation_done_flag, write_busy, busy};
                `OBPS_OFF_ADDR: readdata <= page_addr;
                `OBPS_OFF_OPT: readdata <= {31'h0, read_protect_active};
                `OBPS_OFF_WPS: readdata <= write_protect_status;
                `OBPS_OFF_RDBK: readdata <= opt_img[opt_sel];
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    unlock_order_a: assert property (@(posedge clk) disable iff (rst)
        (write && address == `OBPS_OFF_KEY && writedata == `OBPS_KEY_SECOND && key_state != OBPS_K_HALF)
        |=> !option_write_enable) else $error("enable set without first key");
    unlock_set_a: assert property (@(posedge clk) disable iff (rst)
        (write && address == `OBPS_OFF_KEY && writedata == `OBPS_KEY_SECOND && key_state == OBPS_K_HALF)
        |=> option_write_enable) else $error("enable not set after keys");
    relock_a: assert property (@(posedge clk) disable iff (rst)
        (!option_write_enable && state == OBPS_IDLE) |=> state != OBPS_ERASE && state != OBPS_PROG)
        else $error("option operation while locked");
    busy_ignore_a: assert property (@(posedge clk) disable iff (rst)
        (busy && !t_expired) |=> $stable(state)) else $error("request accepted while busy");
    erase_ones_a: assert property (@(posedge clk) disable iff (rst)
        (state == OBPS_ERASE && t_expired) |=> opt_img[0] == `OBPS_ERASED) else $error("erase left zeros");
    done_set_a: assert property (@(posedge clk) disable iff (rst)
        (state == OBPS_ERASE && t_expired) |=> operation_done_flag && !busy) else $error("no done after erase");
    rdp_hold_a: assert property (@(posedge clk) disable iff (rst)
        !reload_pending |=> $stable(read_protect_active)) else $error("protect changed without reload");
    merase_a: assert property (@(posedge clk) disable iff (rst)
        (state == OBPS_PROG && t_expired && lift_pending) |=> main_erase_req[*2]) else $error("no main erase");
    load_adv_a: assert property (@(posedge clk) disable iff (rst)
        (state == OBPS_LOAD && t_expired) |=> load_ptr == $past(load_ptr) + 1'b1) else $error("pointer stuck");
    erase_c: cover property (@(posedge clk) disable iff (rst) state == OBPS_ERASE && t_expired);
    prog_c: cover property (@(posedge clk) disable iff (rst) state == OBPS_PROG && t_expired);
    merase_c: cover property (@(posedge clk) disable iff (rst) main_erase_req);
endmodule
`default_nettype wire

// ===== verif/tb_obps_seq.sv
// self-checking bench of the option byte sequencer over its avalon-mm slave
`timescale 1ns/100ps
`default_nettype none
`include "obps_regs.svh"
module tb_obps_seq;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic main_erase_req;
    logic [31:0] prog_word;
    logic prog_word_valid;
    logic [3:0] prog_word_idx;
    int num_errors = 0;
    int checks_done = 0;
    int me_cycles = 0;
    logic [31:0] seed = 32'h10;
    logic [31:0] eq[$];
    logic [31:0] mq[$];
    logic [35:0] wq[$];
    logic s_wait, s_rd, s_pv;
    logic [31:0] s_data, s_pw, n_e, n_m, dmy;
    logic [3:0] s_pi;
    always #10 clk = ~clk;
    obps_seq #(.WORDS(16), .OPT_WORDS(4), .TW(16)) i_dut (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .main_erase_req(main_erase_req), .prog_word(prog_word), .prog_word_valid(prog_word_valid),
        .prog_word_idx(prog_word_idx));
    ////////////////////////////////////////////////////////////////
    // sample at the falling edge: outputs are settled and are what the next rising edge sees
    always @(negedge clk) begin
        s_wait = waitrequest;
        s_rd = read;
        s_data = readdata;
        s_pv = prog_word_valid;
        s_pw = prog_word;
        s_pi = prog_word_idx;
        if (main_erase_req === 1'b1) me_cycles++;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
        checks_done++;
        if ((got & msk) !== (exp & msk)) begin
            num_errors++;
            $display("Error t=%0t read %h expected %h", $time, got & msk, exp & msk);
        end
    endtask
    task automatic cmp_word(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t array word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_cnt(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            num_errors++;
            $display("Error t=%0t main erase cycles %0d expected %0d", $time, got, exp);
        end
    endtask
    // monitor: each answer takes the oldest note; a zero mask marks a poll
    always @(posedge clk) begin
        if (s_rd === 1'b1 && s_wait === 1'b0) begin
            n_e = eq.pop_front();
            n_m = mq.pop_front();
            if (n_m != 32'h0) cmp_rd(s_data, n_e, n_m);
        end
        if (s_pv === 1'b1) cmp_word({s_pi, s_pw}, (wq.size() > 0) ? wq.pop_front() : 36'hF_FFFF_FFFF);
    end
    ////////////////////////////////////////////////////////////////
    // one avalon transfer, request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] exp,
        input logic [31:0] msk, output logic [31:0] rd);
        int n;
        n = 0;
        address <= a;
        writedata <= wd;
        read <= !wr;
        write <= wr;
        if (!wr) begin
            eq.push_back(exp);
            mq.push_back(msk);
        end
        // request ends and read data is taken at the rising edge that sees waitrequest low
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        rd = readdata;
        if (n >= 50) num_errors++;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0, 32'h0, dmy);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus(1'b0, a, 32'h0, e, m, dmy);
    endtask
    // poll a status bit low; bounded so a stuck flag cannot hang the run
    task automatic wait_clear(input int b);
        int k;
        logic [31:0] d;
        for (k = 0; k < 2000; k++) begin
            bus(1'b0, `OBPS_OFF_STAT, 32'h0, 32'h0, 32'h0, d);
            if (d[b] === 1'b0) break;
        end
        if (k == 2000) num_errors++;
    endtask
    task automatic unlock();
        wr(`OBPS_OFF_KEY, `OBPS_KEY_FIRST);
        wr(`OBPS_OFF_KEY, `OBPS_KEY_SECOND);
    endtask
    task automatic opt_erase();
        wr(`OBPS_OFF_CTRL, 32'h21);
        wr(`OBPS_OFF_CTRL, 32'h23);
        wait_clear(0);
        rdc(`OBPS_OFF_STAT, 32'h4, 32'h5);
        wr(`OBPS_OFF_STAT, 32'h4);
        wr(`OBPS_OFF_CTRL, 32'h20);
    endtask
    // fast page: clear, 16 loads of staged words, address, start; a second start while busy
    task automatic prog_page(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2,
        input logic [31:0] w3);
        int i;
        logic [31:0] w;
        wait_clear(0);
        // buffer clear is only honoured once fast page mode is already on
        wr(`OBPS_OFF_CTRL, 32'h24);
        wr(`OBPS_OFF_CTRL, 32'h2C);
        wait_clear(0);
        rdc(`OBPS_OFF_STAT, 32'h4, 32'h7);
        wr(`OBPS_OFF_STAT, 32'h4);
        for (i = 0; i < 16; i++) begin
            seed = xs(seed);
            w = (i == 0) ? w0 : (i == 1) ? w1 : (i == 2) ? w2 : (i == 3) ? w3 : seed;
            wq.push_back({4'(i), w});
            wr(`OBPS_OFF_DATA, w);
            wr(`OBPS_OFF_CTRL, 32'h34);
            wait_clear(1);
        end
        wr(`OBPS_OFF_ADDR, 32'h0);
        wr(`OBPS_OFF_CTRL, 32'h26);
        wr(`OBPS_OFF_CTRL, 32'h26);
        wait_clear(0);
        rdc(`OBPS_OFF_STAT, 32'h4, 32'hD);
        wr(`OBPS_OFF_STAT, 32'h4);
        wr(`OBPS_OFF_CTRL, 32'h20);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // watchdog sized well above the roughly 1500 cycles the tests need
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rdc(`OBPS_OFF_OPT, 32'h0, 32'h1);
        rdc(`OBPS_OFF_WPS, 32'hA5A5A5A5, 32'hFFFFFFFF);
        wr(`OBPS_OFF_CTRL, 32'h03);
        rdc(`OBPS_OFF_STAT, 32'h8, 32'h9);
        wr(`OBPS_OFF_STAT, 32'h8);
        rdc(`OBPS_OFF_STAT, 32'h0, 32'h8);
        $display("test reset and refusal done");
        wr(`OBPS_OFF_KEY, `OBPS_KEY_FIRST);
        wr(`OBPS_OFF_KEY, 32'h0);
        wr(`OBPS_OFF_KEY, `OBPS_KEY_SECOND);
        rdc(`OBPS_OFF_CTRL, 32'h0, 32'h20);
        unlock();
        rdc(`OBPS_OFF_CTRL, 32'h20, 32'h20);
        wr(`OBPS_OFF_CTRL, 32'h0);
        rdc(`OBPS_OFF_CTRL, 32'h0, 32'h20);
        $display("test unlock done");
        unlock();
        opt_erase();
        for (int k = 0; k < 4; k++) begin
            wr(`OBPS_OFF_ADDR, 32'(k * 4));
            rdc(`OBPS_OFF_RDBK, `OBPS_ERASED, 32'hFFFFFFFF);
        end
        $display("test option erase done");
        prog_page(32'h5AA5FF00, 32'h5AA55AA5, 32'hF00FCC33, 32'h3CC3E11E);
        wr(`OBPS_OFF_ADDR, 32'h0);
        rdc(`OBPS_OFF_RDBK, 32'h5AA5FF00, 32'hFFFFFFFF);
        rdc(`OBPS_OFF_OPT, 32'h0, 32'h1);
        rdc(`OBPS_OFF_WPS, 32'hA5A5A5A5, 32'hFFFFFFFF);
        cmp_cnt(me_cycles, 0);
        $display("test page program done");
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rdc(`OBPS_OFF_OPT, 32'h1, 32'h1);
        rdc(`OBPS_OFF_WPS, 32'hC31E0F33, 32'hFFFFFFFF);
        rdc(`OBPS_OFF_CTRL, 32'h0, 32'h20);
        unlock();
        opt_erase();
        rdc(`OBPS_OFF_OPT, 32'h1, 32'h1);
        me_cycles = 0;
        prog_page(`OBPS_OPT_DEFAULT, 32'h5AA55AA5, 32'h5AA55AA5, 32'h5AA55AA5);
        cmp_cnt(me_cycles, 400);
        $display("test protection lift done");
        if (eq.size() != 0 || wq.size() != 0) num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
